// >>> src/poll_pkg.sv
// Purpose: shared constants and carriers for the multidrop polling master
// Assumes: byte-wide link and host streams
// Notes: poll frames are one address byte out, data bytes back, end byte closes (probe takes the first byte only); config frames are two bytes out
package poll_pkg;
  localparam int MAX_SLAVES = 31;
  localparam logic [4:0] MASTER_ADDR = 5'h00;
  localparam logic [4:0] FIRST_SLAVE = 5'h01;
  localparam logic [7:0] CHAR_FOUND = 8'h53;
  localparam logic [7:0] CHAR_TIMEOUT = 8'h54;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] POLL_FLAG = 8'h80;
  localparam logic [7:0] CFG_FLAG = 8'hC0;
  localparam logic [7:0] END_BYTE = 8'h03;
  localparam int CLK_MHZ = 250;
  localparam int RESP_TIMEOUT_US = 100;
  localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_US * CLK_MHZ;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } byte_s;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
  } cfg_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_SEND = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_FWD = 4'b0011,
    ST_TENS = 4'b0100,
    ST_ONES = 4'b0101,
    ST_MARK = 4'b0110,
    ST_EOL = 4'b0111,
    ST_NEXT = 4'b1000,
    ST_CFG = 4'b1001
  } poll_state_e;
endpackage : poll_pkg

// >>> src/skid_buf.sv
// Purpose: two-entry buffer between collected slave data and the host port
// Assumes: single clock, synchronous active-high reset
// Notes: in_ready depends only on state; while full, report bytes wait but slave bytes offered in ST_FWD are lost
`timescale 1ns/1ps
module skid_buf #(
  parameter int W = 9
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic vld_q;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  assign in_ready = (cnt_q != 2'h2);
  // valid kept in its own flop so the host sees a registered strobe
  assign out_valid = vld_q;
  assign out_data = mem_q[rp_q];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
      vld_q <= 1'b0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_d;
      vld_q <= (cnt_d != 2'h0);
    end
  end
endmodule : skid_buf

// >>> src/poll_master.sv
// Purpose: polling master of a two-wire multidrop reader network
// Assumes: byte-level UART framing and the RS-485 driver sit outside
// Notes: power-up probe reports each address, then cyclic polling
`timescale 1ns/1ps
module poll_master
  import poll_pkg::*;
#(
  parameter int TIMEOUT_CYC = poll_pkg::RESP_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // setting
  input wire logic [4:0] last_slave,
  // bus transmit stream
  output poll_pkg::byte_s bus_tx,
  output logic bus_tx_valid,
  input wire logic bus_tx_ready,
  output logic bus_drive_en,
  // bus receive stream, asynchronous pin side
  input wire logic [7:0] bus_rx_data,
  input wire logic bus_rx_stb,
  // host transmit stream
  output poll_pkg::byte_s host_tx,
  output logic host_tx_valid,
  input wire logic host_tx_ready,
  // configuration relay request
  input wire poll_pkg::cfg_s cfg_req,
  input wire logic cfg_valid,
  output logic cfg_ready,
  // status
  output logic init_done,
  output logic [MAX_SLAVES:1] alive_map,
  output logic termination_supply
);
  import poll_pkg::*;

  localparam int TW = $clog2(TIMEOUT_CYC + 1);

  poll_state_e state_q;
  logic [4:0] addr_q;
  logic [4:0] last_s1_q;
  logic [4:0] last_q;
  logic init_q;
  logic found_q;
  logic [TW-1:0] tmr_q;
  logic [MAX_SLAVES:1] alive_q;
  logic [7:0] rx_data_s1_q;
  logic [7:0] rx_data_s2_q;
  logic rx_stb_s1_q;
  logic rx_stb_s2_q;
  logic rx_stb_s3_q;
  logic rx_new;
  byte_s tx_q;
  logic tx_valid_q;
  byte_s buf_in;
  logic buf_valid;
  logic buf_ready;
  byte_s buf_out;
  logic buf_out_valid;
  cfg_s cfg_q;

  // ******************************************
  // helpers
  // ******************************************
  function automatic logic [7:0] tens_char(input logic [4:0] a);
    tens_char = CHAR_ZERO + 8'(a / 5'h0A);
  endfunction : tens_char

  function automatic logic [7:0] ones_char(input logic [4:0] a);
    ones_char = CHAR_ZERO + 8'(a % 5'h0A);
  endfunction : ones_char

  function automatic logic [4:0] clamp_last(input logic [4:0] v);
    clamp_last = (v > 5'(MAX_SLAVES)) ? 5'(MAX_SLAVES) : v;
  endfunction : clamp_last

  // ******************************************
  // receive synchroniser
  // ******************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_stb_s1_q <= 1'b0;
      rx_stb_s2_q <= 1'b0;
      rx_stb_s3_q <= 1'b0;
      rx_data_s1_q <= 8'h00;
      rx_data_s2_q <= 8'h00;
    end else begin
      rx_stb_s1_q <= bus_rx_stb;
      rx_stb_s2_q <= rx_stb_s1_q;
      rx_stb_s3_q <= rx_stb_s2_q;
      rx_data_s1_q <= bus_rx_data;
      rx_data_s2_q <= rx_data_s1_q;
    end
  end

  assign rx_new = rx_stb_s2_q && !rx_stb_s3_q;

  // ******************************************
  // setting capture
  // ******************************************
  // two-flop capture, no reset: settled before release, so no false zero
  always_ff @(posedge clk_sys) begin
    last_s1_q <= last_slave;
    last_q <= clamp_last(last_s1_q);
  end

  // ******************************************
  // sequencer
  // ******************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_IDLE;
      addr_q <= FIRST_SLAVE;
      init_q <= 1'b1;
      found_q <= 1'b0;
      tmr_q <= '0;
      tx_q <= '0;
      tx_valid_q <= 1'b0;
      cfg_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (last_q == MASTER_ADDR) begin
            init_q <= 1'b0;
          end else if (!init_q && cfg_valid) begin
            cfg_q <= cfg_req;
            tx_q <= '{data: CFG_FLAG | 8'(cfg_req.addr), last: 1'b0};
            tx_valid_q <= 1'b1;
            state_q <= ST_CFG;
          end else if (addr_q > last_q) begin
            state_q <= ST_NEXT;
          end else if (init_q || alive_q[addr_q]) begin
            tx_q <= '{data: POLL_FLAG | 8'(addr_q), last: 1'b1};
            tx_valid_q <= 1'b1;
            state_q <= ST_SEND;
          end else begin
            state_q <= ST_NEXT;
          end
        end
        ST_CFG: begin
          if (tx_valid_q && bus_tx_ready) begin
            if (tx_q.last) begin
              tx_valid_q <= 1'b0;
              state_q <= ST_IDLE;
            end else begin
              tx_q <= '{data: cfg_q.data, last: 1'b1};
            end
          end
        end
        ST_SEND: begin
          if (bus_tx_ready) begin
            tx_valid_q <= 1'b0;
            tmr_q <= TW'(TIMEOUT_CYC);
            found_q <= 1'b0;
            state_q <= init_q ? ST_WAIT : ST_FWD;
          end
        end
        ST_WAIT: begin
          if (rx_new) begin
            found_q <= 1'b1;
            state_q <= ST_TENS;
          end else if (tmr_q == '0) begin
            state_q <= ST_TENS;
          end else begin
            tmr_q <= tmr_q - TW'(1);
          end
        end
        ST_FWD: begin
          if (rx_new && buf_ready) begin
            tmr_q <= TW'(TIMEOUT_CYC);
            if (rx_data_s2_q == END_BYTE) begin
              state_q <= ST_NEXT;
            end
          end else if (tmr_q == '0) begin
            state_q <= ST_NEXT;
          end else begin
            tmr_q <= tmr_q - TW'(1);
          end
        end
        ST_TENS: begin
          if (buf_ready) begin
            state_q <= ST_ONES;
          end
        end
        ST_ONES: begin
          if (buf_ready) begin
            state_q <= ST_MARK;
          end
        end
        ST_MARK: begin
          if (buf_ready) begin
            state_q <= ST_EOL;
          end
        end
        ST_EOL: begin
          if (buf_ready) begin
            state_q <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (addr_q >= last_q) begin
            addr_q <= FIRST_SLAVE;
            init_q <= 1'b0;
          end else begin
            addr_q <= addr_q + 5'h01;
          end
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ******************************************
  // live slave map
  // ******************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alive_q <= '0;
    end else if (state_q == ST_WAIT && rx_new) begin
      alive_q[addr_q] <= 1'b1;
    end else if (state_q == ST_WAIT && tmr_q == '0) begin
      alive_q[addr_q] <= 1'b0;
    end
  end

  // ******************************************
  // host byte source
  // ******************************************
  always_comb begin
    buf_in = '0;
    buf_valid = 1'b0;
    unique case (state_q)
      ST_FWD: begin
        buf_in = '{data: rx_data_s2_q, last: (rx_data_s2_q == END_BYTE)};
        buf_valid = rx_new;
      end
      ST_TENS: begin
        buf_in = '{data: tens_char(addr_q), last: 1'b0};
        buf_valid = 1'b1;
      end
      ST_ONES: begin
        buf_in = '{data: ones_char(addr_q), last: 1'b0};
        buf_valid = 1'b1;
      end
      ST_MARK: begin
        buf_in = '{data: found_q ? CHAR_FOUND : CHAR_TIMEOUT, last: 1'b0};
        buf_valid = 1'b1;
      end
      ST_EOL: begin
        buf_in = '{data: CHAR_CR, last: 1'b1};
        buf_valid = 1'b1;
      end
      default: begin
        buf_in = '0;
        buf_valid = 1'b0;
      end
    endcase
  end

  skid_buf #(
    .W($bits(byte_s))
  ) u_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(buf_valid),
    .in_ready(buf_ready),
    .in_data(buf_in),
    .out_valid(buf_out_valid),
    .out_ready(host_tx_ready),
    .out_data(buf_out)
  );

  // ******************************************
  // registered outputs
  // ******************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_drive_en <= 1'b0;
      init_done <= 1'b0;
      alive_map <= '0;
      termination_supply <= 1'b0;
      cfg_ready <= 1'b0;
    end else begin
      bus_drive_en <= tx_valid_q;
      init_done <= !init_q;
      alive_map <= alive_q;
      termination_supply <= 1'b1;
      cfg_ready <= (state_q == ST_IDLE) && !init_q && cfg_valid && !cfg_ready &&
                   (last_q != MASTER_ADDR);
    end
  end

  assign bus_tx = tx_q;
  assign bus_tx_valid = tx_valid_q;
  assign host_tx = buf_out;
  assign host_tx_valid = buf_out_valid;
endmodule : poll_master

// >>> sim/poll_master_monitor.sv
// Purpose: checker on the polling master ports
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto every poll_master
`timescale 1ns/1ps
module poll_master_monitor
  import poll_pkg::*;
#(
  parameter int TIMEOUT_CYC = 20
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // watched ports
  input wire logic [4:0] last_slave,
  input wire poll_pkg::byte_s bus_tx,
  input wire logic bus_tx_valid,
  input wire logic bus_tx_ready,
  input wire logic bus_drive_en,
  input wire poll_pkg::byte_s host_tx,
  input wire logic host_tx_valid,
  input wire logic host_tx_ready,
  input wire logic cfg_ready,
  input wire logic init_done,
  input wire logic [MAX_SLAVES:1] alive_map
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire poll_w = bus_tx_valid && bus_tx.data[7:6] == 2'b10;
  chk_poll_range: assert property (
    poll_w && !$past(bus_tx_valid) |-> bus_tx.data[4:0] != MASTER_ADDR &&
      bus_tx.data[4:0] <= $past(last_slave, 3))
    else $error("poll address out of range");
  chk_dead_skip: assert property (
    init_done && poll_w |-> alive_map[bus_tx.data[4:0]])
    else $error("poll sent to a dropped slave");
  chk_tx_hold: assert property (
    bus_tx_valid && !bus_tx_ready |=> bus_tx_valid && $stable(bus_tx))
    else $error("bus byte changed before taken");
  chk_drive_on: assert property (
    bus_tx_valid |=> bus_drive_en)
    else $error("driver off while sending");
  chk_host_hold: assert property (
    host_tx_valid && !host_tx_ready |=> host_tx_valid && $stable(host_tx))
    else $error("host byte changed before taken");
  chk_init_stays: assert property (
    init_done |=> init_done)
    else $error("init done fell");
  chk_map_frozen: assert property (
    init_done |=> $stable(alive_map))
    else $error("alive map changed after probe");
  chk_cfg_late: assert property (
    cfg_ready |-> init_done)
    else $error("config taken before network runs");
endmodule : poll_master_monitor

bind poll_master poll_master_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_poll_master_monitor (
  .clk_sys(clk_sys), .rst(rst), .last_slave(last_slave), .bus_tx(bus_tx),
  .bus_tx_valid(bus_tx_valid), .bus_tx_ready(bus_tx_ready), .bus_drive_en(bus_drive_en),
  .host_tx(host_tx), .host_tx_valid(host_tx_valid), .host_tx_ready(host_tx_ready),
  .cfg_ready(cfg_ready), .init_done(init_done), .alive_map(alive_map));

// >>> sim/slave_net.sv
// Purpose: behavioural chain of slave readers on the shared bus
// Assumes: byte level link, probe phase told by the bench
// Notes: one data byte on probe, data then end byte on poll
`timescale 1ns/1ps
module slave_net
  import poll_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // stations present, probe phase
  input wire logic [MAX_SLAVES:1] alive,
  input wire logic probing,
  // link
  input wire poll_pkg::byte_s bus_tx,
  input wire logic bus_tx_valid,
  output logic bus_tx_ready,
  output logic [7:0] bus_rx_data,
  output logic bus_rx_stb
);
  logic [1:0] slow_q;
  initial begin
    bus_rx_data = 8'h00;
    bus_rx_stb = 1'b0;
  end
  always_ff @(posedge clk_sys) slow_q <= rst ? 2'h0 : slow_q + 2'h1;
  // stalls one cycle in four
  assign bus_tx_ready = slow_q != 2'h0;
  task automatic send(input logic [7:0] b);
    #1 bus_rx_data = b;
    repeat (4) @(posedge clk_sys);
    #1 bus_rx_stb = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 bus_rx_stb = 1'b0;
    // released line shows no stale value
    bus_rx_data = ~b;
  endtask : send
  task automatic reply(input logic [4:0] a);
    logic p;
    p = probing;
    repeat (2) @(posedge clk_sys);
    send({3'h5, a});
    if (!p) send(END_BYTE);
  endtask : reply
  // answer only a poll of a present nonzero address
  always @(posedge clk_sys) begin
    if (!rst && bus_tx_valid && bus_tx_ready && bus_tx.data[7:6] == 2'h2 &&
        bus_tx.data[4:0] != 5'h00 && alive[bus_tx.data[4:0]] === 1'b1) begin
      fork
        reply(bus_tx.data[4:0]);
      join_none
    end
  end
endmodule : slave_net

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the polling master
// Assumes: short response timeout, slave chain model
// Notes: host stream compared with a queue model
`timescale 1ns/1ps
module tb_top;
  import poll_pkg::*;
  localparam int TO = 20;
  localparam int LAST = 12;
  localparam int NEW_LAST = 7;
  localparam logic [4:0] CFG_ADDR = 5'h04;
  localparam logic [7:0] CFG_DATA = 8'h11;
  logic [4:0] last_slave = 5'(LAST);
  int cfg_bytes = 0;
  int tail = 0;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic host_tx_ready = 1'b0;
  logic cfg_valid = 1'b0;
  logic cfg_ready, init_done, termination_supply, bus_tx_valid, bus_tx_ready;
  logic bus_drive_en, bus_rx_stb, host_tx_valid;
  logic [7:0] bus_rx_data;
  logic [MAX_SLAVES:1] alive = '0;
  logic [MAX_SLAVES:1] alive_map;
  byte_s bus_tx, host_tx;
  cfg_s cfg_req = '0;
  logic [31:0] rng = 32'h33F2;
  logic [8:0] exp_q[$];
  int miscompares = 0;
  int total_checks = 0;
  always #2 clk_sys = ~clk_sys;
  poll_master #(.TIMEOUT_CYC(TO)) i_poll_master (.clk_sys(clk_sys), .rst(rst),
    .last_slave(last_slave), .bus_tx(bus_tx), .bus_tx_valid(bus_tx_valid),
    .bus_tx_ready(bus_tx_ready), .bus_drive_en(bus_drive_en), .bus_rx_data(bus_rx_data),
    .bus_rx_stb(bus_rx_stb), .host_tx(host_tx), .host_tx_valid(host_tx_valid),
    .host_tx_ready(host_tx_ready), .cfg_req(cfg_req), .cfg_valid(cfg_valid),
    .cfg_ready(cfg_ready), .init_done(init_done), .alive_map(alive_map),
    .termination_supply(termination_supply));
  slave_net i_slave_net (.clk_sys(clk_sys), .rst(rst), .alive(alive), .probing(!init_done),
    .bus_tx(bus_tx), .bus_tx_valid(bus_tx_valid), .bus_tx_ready(bus_tx_ready),
    .bus_rx_data(bus_rx_data), .bus_rx_stb(bus_rx_stb));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // host stalls at random
  always @(negedge clk_sys) begin
    rng = xs(rng);
    host_tx_ready <= rng[3] | rng[7];
  end
  always @(posedge clk_sys) begin
    if (!rst && host_tx_valid && host_tx_ready) begin
      if (exp_q.size() > 0) check("host byte", exp_q.pop_front(), host_tx);
      else check("host extra byte", 0, 1);
    end
  end
  // relayed configuration pair on the bus
  always @(posedge clk_sys) begin
    if (!rst && bus_tx_valid && bus_tx_ready) begin
      if (cfg_bytes == 1) begin
        check("cfg data", {CFG_DATA, 1'b1}, bus_tx);
        cfg_bytes = 2;
      end else if (bus_tx.data[7:6] == 2'b11) begin
        check("cfg head", {CFG_FLAG | 8'(CFG_ADDR), 1'b0}, bus_tx);
        cfg_bytes = 1;
      end
    end
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    miscompares++;
    close_out();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    for (int a = 1; a <= LAST; a++) begin
      alive[a] = (a % 3 == 1) || a == LAST;
      exp_q.push_back({8'(CHAR_ZERO + a / 10), 1'b0});
      exp_q.push_back({8'(CHAR_ZERO + a % 10), 1'b0});
      exp_q.push_back({alive[a] ? CHAR_FOUND : CHAR_TIMEOUT, 1'b0});
      exp_q.push_back({CHAR_CR, 1'b1});
    end
    for (int r = 0; r < 4; r++) begin
      for (int a = 1; a <= ((r < 2) ? LAST : NEW_LAST); a++) begin
        if (alive[a]) begin
          exp_q.push_back({3'h5, 5'(a), 1'b0});
          exp_q.push_back({END_BYTE, 1'b1});
          if (r >= 2) tail += 2;
        end
      end
    end
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    @(negedge clk_sys);
    check("termination", 1, termination_supply);
    for (int i = 0; i < 5000 && init_done !== 1'b1; i++) @(posedge clk_sys);
    check("init done", 1, init_done);
    check("alive map", alive, alive_map);
    $display("test probe done");
    @(negedge clk_sys);
    cfg_req = '{addr: CFG_ADDR, data: CFG_DATA};
    cfg_valid = 1'b1;
    for (int i = 0; i < 2000 && cfg_ready !== 1'b1; i++) @(posedge clk_sys);
    check("cfg taken", 1, cfg_ready);
    @(negedge clk_sys) cfg_valid = 1'b0;
    $display("test config done");
    for (int i = 0; i < 8000 && exp_q.size() > tail; i++) @(posedge clk_sys);
    check("cfg bytes", 2, cfg_bytes);
    $display("test polling done");
    @(negedge clk_sys) last_slave = 5'(NEW_LAST);
    for (int i = 0; i < 8000 && exp_q.size() > 0; i++) @(posedge clk_sys);
    check("host bytes left", 0, exp_q.size());
    $display("test range done");
    close_out();
  end
endmodule : tb_top
